/* File: hw/qfp_pipeline.v */
`timescale 1ns/1ns
`default_nettype none
`include "qfp_defs.vh"
module qfp_pipeline (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Oscillator pin, divided into phases
  input wire oscillator_input_pin,
  // Program memory read port, combinational data
  input wire [13:0] prog_rdata,
  // Branch request from execute logic, sampled in phase four
  input wire branch_req,
  input wire [12:0] branch_target,
  // Interrupt entry request, sampled in phase four
  input wire irq_req,
  // Phase outputs
  output reg phase_one_ff,
  output reg phase_two_ff,
  output reg phase_three_ff,
  output reg phase_four_ff,
  // Program memory address
  output reg [12:0] prog_addr_ff,
  // Executing instruction
  output reg [13:0] instr_ff,
  output reg instr_valid_ff,
  // Execute stage strobes
  output reg data_rd_ff,
  output reg data_wr_ff,
  output reg exec_ff,
  output reg retire_ff
);
  wire osc_tick;
  wire [3:0] phase;
  reg [12:0] pc_ff;
  reg [13:0] fetch_ff;
  reg fetch_valid_ff;
  reg redirect_ff;
  reg [12:0] redirect_pc_ff;
  reg [12:0] nxt_pc;
  reg [13:0] nxt_fetch;
  reg nxt_fetch_valid;
  reg [13:0] nxt_instr;
  reg nxt_instr_valid;
  reg nxt_redirect;
  reg [12:0] nxt_redirect_pc;
  wire ph1;
  wire ph2;
  wire ph4;
  wire ph1_next;
  wire ph2_next;
  wire ph4_next;
  wire take_branch;

  // Oscillator synchroniser and edge detect
  qfp_osc_sync u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .oscillator_input_pin(oscillator_input_pin),
    .tick_ff(osc_tick)
  );

  // Quadrature phase generator
  qfp_phase_gen u_phase (
    .clock(clock),
    .arst_n(arst_n),
    .osc_tick(osc_tick),
    .phase_ff(phase)
  );

  // Phase entry strobes: tick ending the previous phase
  assign ph1 = osc_tick & phase[3];
  assign ph2 = osc_tick & phase[0];
  assign ph4 = osc_tick & phase[2];
  // End of phase four closes the cycle
  assign ph1_next = ph1;
  assign ph2_next = ph2;
  assign ph4_next = ph4;
  // Branch decided by the executing valid instruction
  assign take_branch = instr_valid_ff & (branch_req | irq_req);

  // Pipeline next-state logic
  always @* begin
    nxt_pc = pc_ff;
    nxt_fetch = fetch_ff;
    nxt_fetch_valid = fetch_valid_ff;
    nxt_instr = instr_ff;
    nxt_instr_valid = instr_valid_ff;
    nxt_redirect = redirect_ff;
    nxt_redirect_pc = redirect_pc_ff;
    if (ph1_next) begin
      // Fetched word moves into execute
      nxt_instr = fetch_ff;
      nxt_instr_valid = fetch_valid_ff;
      if (redirect_ff) begin
        // Target address takes effect for this fetch
        nxt_pc = redirect_pc_ff;
        nxt_redirect = 1'b0;
      end else begin
        nxt_pc = pc_ff + 13'h0001;
      end
    end
    if (ph4_next) begin
      // Capture program word as phase four begins
      nxt_fetch = prog_rdata;
      nxt_fetch_valid = 1'b1;
      if (take_branch) begin
        // Prefetched word flushed, costs one extra cycle
        nxt_fetch = `QFP_NOP_WORD;
        nxt_fetch_valid = 1'b0;
        nxt_redirect = 1'b1;
        nxt_redirect_pc = irq_req ? `QFP_INT_VEC : branch_target;
      end
    end
  end

  // Pipeline registers
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // Start at reset vector, pipeline empty
      pc_ff <= `QFP_RESET_VEC;
      fetch_ff <= `QFP_NOP_WORD;
      fetch_valid_ff <= 1'b0;
      instr_ff <= `QFP_NOP_WORD;
      instr_valid_ff <= 1'b0;
      redirect_ff <= 1'b1;
      redirect_pc_ff <= `QFP_RESET_VEC;
    end else begin
      pc_ff <= nxt_pc;
      fetch_ff <= nxt_fetch;
      fetch_valid_ff <= nxt_fetch_valid;
      instr_ff <= nxt_instr;
      instr_valid_ff <= nxt_instr_valid;
      redirect_ff <= nxt_redirect;
      redirect_pc_ff <= nxt_redirect_pc;
    end
  end

  // Registered phase, address and stage strobes
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_one_ff <= 1'b0;
      phase_two_ff <= 1'b0;
      phase_three_ff <= 1'b0;
      phase_four_ff <= 1'b0;
      prog_addr_ff <= `QFP_RESET_VEC;
      data_rd_ff <= 1'b0;
      data_wr_ff <= 1'b0;
      exec_ff <= 1'b0;
      retire_ff <= 1'b0;
    end else begin
      // Phases shown after first oscillator tick
      if (osc_tick) begin
        phase_one_ff <= phase[3];
        phase_two_ff <= phase[0];
        phase_three_ff <= phase[1];
        phase_four_ff <= phase[2];
      end
      prog_addr_ff <= nxt_pc;
      // Execute occupies phases two to four
      if (osc_tick) begin
        exec_ff <= instr_valid_ff & ~phase[3];
      end
      if (ph1_next) begin
        exec_ff <= 1'b0;
      end
      data_rd_ff <= ph2_next & instr_valid_ff;
      data_wr_ff <= ph4_next & instr_valid_ff;
      // Pulse as a valid word enters execute
      retire_ff <= ph1_next & fetch_valid_ff;
    end
  end
endmodule
`default_nettype wire

/* File: hw/qfp_defs.vh */
`ifndef QFP_DEFS_VH
`define QFP_DEFS_VH
`define QFP_PC_W 13
`define QFP_WORD_W 14
`define QFP_RESET_VEC 13'h0000
`define QFP_INT_VEC 13'h0004
`define QFP_NOP_WORD 14'h0000
`define QFP_PH_ONE 4'h1
`define QFP_PH_TWO 4'h2
`define QFP_PH_THREE 4'h4
`define QFP_PH_FOUR 4'h8
`endif

/* File: hw/qfp_phase_gen.v */
`timescale 1ns/1ns
`default_nettype none
`include "qfp_defs.vh"
module qfp_phase_gen (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Synchronised oscillator edge enable
  input wire osc_tick,
  // One-hot phase, one bit per phase
  output reg [3:0] phase_ff
);
  reg [3:0] nxt_phase;

  // Rotate one-hot phase on each oscillator tick
  always @* begin
    nxt_phase = phase_ff;
    if (osc_tick) begin
      nxt_phase = {phase_ff[2:0], phase_ff[3]};
    end
  end

  // Phase four held in reset so first tick gives phase one
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= `QFP_PH_FOUR;
    end else begin
      phase_ff <= nxt_phase;
    end
  end
endmodule
`default_nettype wire

/* File: hw/qfp_osc_sync.v */
`timescale 1ns/1ns
`default_nettype none
module qfp_osc_sync (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Raw oscillator pin
  input wire oscillator_input_pin,
  // One-cycle pulse per rising oscillator edge
  output reg tick_ff
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  // Two-stage synchroniser, then rising edge detect
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      meta_ff <= oscillator_input_pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      tick_ff <= sync_ff & ~prev_ff;
    end
  end
endmodule
`default_nettype wire

/* File: test/qfp_pipeline_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module qfp_pipeline_asserts (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Inputs of the block
  input wire oscillator_input_pin,
  input wire [13:0] prog_rdata,
  input wire branch_req,
  input wire [12:0] branch_target,
  input wire irq_req,
  // Outputs of the block
  input wire phase_one_ff,
  input wire phase_two_ff,
  input wire phase_three_ff,
  input wire phase_four_ff,
  input wire [12:0] prog_addr_ff,
  input wire [13:0] instr_ff,
  input wire instr_valid_ff,
  input wire data_rd_ff,
  input wire data_wr_ff,
  input wire exec_ff,
  input wire retire_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Phase generator shape
  a_phase_onehot: assert property ($onehot0({phase_one_ff, phase_two_ff,
    phase_three_ff, phase_four_ff})) else $error("phases overlap");
  a_phase_order: assert property ($fell(phase_one_ff) |-> phase_two_ff)
    else $error("phase two does not follow one");
  a_phase_hold: assert property ($rose(phase_one_ff) |=> phase_one_ff[*8])
    else $error("phase one too short");
  // Counter and execute strobes
  a_pc_phase: assert property (!$stable(prog_addr_ff) |->
    phase_one_ff || $past(phase_one_ff)) else $error("pc moved outside phase one");
  a_rd_phase: assert property (data_rd_ff |-> instr_valid_ff &&
    (phase_two_ff || $past(phase_two_ff))) else $error("read outside phase two");
  a_wr_phase: assert property (data_wr_ff |-> instr_valid_ff &&
    (phase_four_ff || $past(phase_four_ff))) else $error("write outside phase four");
  a_exec_start: assert property ($rose(exec_ff) |-> phase_two_ff)
    else $error("execute not starting in phase two");
  a_retire_gap: assert property (retire_ff |=> !retire_ff[*8])
    else $error("retire pulses too close");
  // Main scenarios
  c_retire: cover property ($rose(retire_ff));
  c_write: cover property (data_wr_ff);
  c_branch: cover property (instr_valid_ff && branch_req && phase_four_ff);
endmodule
bind qfp_pipeline qfp_pipeline_asserts i_chk (.clock, .arst_n, .oscillator_input_pin,
  .prog_rdata, .branch_req, .branch_target, .irq_req, .phase_one_ff, .phase_two_ff,
  .phase_three_ff, .phase_four_ff, .prog_addr_ff, .instr_ff, .instr_valid_ff,
  .data_rd_ff, .data_wr_ff, .exec_ff, .retire_ff);
`default_nettype wire

/* File: test/qfp_pipeline_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module qfp_pipeline_bench;
  localparam integer CYC = 64; // Four phases of sixteen clocks
  reg clock = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] osc_cnt = 4'h0;
  reg [13:0] prog_rdata = 14'h0000;
  reg branch_req = 1'b0;
  reg irq_req = 1'b0;
  reg [12:0] branch_target = 13'h0000;
  wire oscillator_input_pin = osc_cnt[3];
  wire [12:0] prog_addr_ff;
  wire [13:0] instr_ff;
  wire phase_one_ff, phase_two_ff, phase_three_ff, phase_four_ff;
  wire instr_valid_ff, data_rd_ff, data_wr_ff, exec_ff, retire_ff;
  integer err_total = 0;
  integer check_count = 0;
  integer gap, n_rd, n_wr, n_ex;
  qfp_pipeline i_dut (.clock, .arst_n, .oscillator_input_pin, .prog_rdata, .branch_req,
    .branch_target, .irq_req, .phase_one_ff, .phase_two_ff, .phase_three_ff,
    .phase_four_ff, .prog_addr_ff, .instr_ff, .instr_valid_ff, .data_rd_ff,
    .data_wr_ff, .exec_ff, .retire_ff);
  // Clock, oscillator of sixteen clocks, program memory word = {1, address}
  always #4 clock = ~clock;
  always @(posedge clock) osc_cnt <= osc_cnt + 4'h1;
  always @(posedge clock) prog_rdata <= {1'b1, prog_addr_ff};
  task check(input [13:0] seen, input [13:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Next retire, counting clocks and strobes on the way
  task step(input [13:0] w, input integer g);
    begin
      gap = 0;
      n_rd = 0;
      n_wr = 0;
      n_ex = 0;
      @(posedge clock);
      while (retire_ff !== 1'b1 && gap < 300) begin
        n_rd = n_rd + (data_rd_ff === 1'b1);
        n_wr = n_wr + (data_wr_ff === 1'b1);
        n_ex = n_ex + (exec_ff === 1'b1);
        @(posedge clock);
        gap = gap + 1;
      end
      @(posedge clock);
      check(instr_ff, w);
      check({8'h00, phase_one_ff, phase_two_ff, phase_three_ff, phase_four_ff,
        instr_valid_ff, exec_ff}, 14'h0022);
      if (g > 0) check(n_ex[13:0], 14'h0030);
      if (g > 0) check(gap[13:0], g[13:0] - 14'h0002);
      if (g > 0) check({n_rd[6:0], n_wr[6:0]}, 14'h0081);
    end
  endtask
  task t_reset_start;
    begin
      check({instr_valid_ff, retire_ff, data_rd_ff, data_wr_ff, exec_ff}, 14'h0000);
      check({1'b0, prog_addr_ff}, 14'h0000);
      arst_n <= 1'b1;
      step(14'h2000, 0);
    end
  endtask
  task t_sequential;
    begin
      step(14'h2001, CYC);
      step(14'h2002, CYC);
    end
  endtask
  task t_branch;
    begin
      branch_req <= 1'b1;
      branch_target <= 13'h0100;
      step(14'h2100, 2 * CYC);
      branch_req <= 1'b0;
      step(14'h2101, CYC);
    end
  endtask
  task t_irq;
    begin
      irq_req <= 1'b1;
      branch_req <= 1'b1;
      step(14'h2004, 2 * CYC);
      irq_req <= 1'b0;
      branch_req <= 1'b0;
      step(14'h2005, CYC);
    end
  endtask
  task end_of_test;
    begin
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    t_reset_start;
    t_sequential;
    t_branch;
    t_irq;
    end_of_test;
  end
  // Watchdog
  initial begin
    #40000;
    err_total = err_total + 1;
    end_of_test;
  end
endmodule
`default_nettype wire
